// *** btc_timer.sv ***
`timescale 1ns/100ps
`include "btc_regs.svh"
// Contract
// [R1] counter, period, compares, buffers are 16-bit
// [R2] detect bottom, max and top values
// [R3] compare count with zero, period, compares
// [R4] top/bottom/match outputs follow next tick
// [R5] tick from prescaler or event input
// [R6] update copies valid buffers unless locked
// [R7] buffer write sets valid; update clears it
// [R8] enable starts counting at prescaler rate
// [R9] event-count enable counts events instead
// [R10] direction bit writable while running
// [R11] up-count wraps to zero after top
// [R12] down-count reloads period after bottom
// [R13] count write immediate and wins
// [R14] active compares directly writable too
// [R15] unbuffered period write is immediate
// [R16] new period below count: run to wrap
// [R17] period buffer active only on update
// [R18] tick clears, reloads, increments or decrements
// [R19] events may set direction or restart
// [R20] split mode: two 8-bit counters
// [R21] channel matches when count equals compare
// [R22] update at top up, bottom down
module btc_timer
    import btc_pkg::*;
#(
    parameter int NUM_CMP = 3,
    parameter int PSC_W = 10
) (
    // system
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // event system
    input wire logic event_tick,
    input wire logic event_dir,
    input wire logic event_restart,
    // event and waveform outputs
    output logic top_event,
    output logic bottom_event,
    output logic [NUM_CMP-1:0] waveform_out_n
);

    // ********************************************************
    // registers
    // ********************************************************
    logic [31:0] control_a_reg;
    logic [31:0] event_control_reg;
    logic lock_update_reg;
    logic [15:0] count_value_reg;
    logic [15:0] period_reg;
    logic [15:0] period_buffer_reg;
    logic period_buffer_valid_reg;
    logic [15:0] compare_value_n_reg [NUM_CMP];
    logic [15:0] compare_buffer_n_reg [NUM_CMP];
    logic [NUM_CMP-1:0] compare_buffer_valid_n_reg;
    logic [PSC_W-1:0] psc_reg;
    logic top_seen_reg;
    logic bottom_seen_reg;
    logic max_seen_reg;
    logic [NUM_CMP-1:0] match_seen_reg;
    btc_bus_state_t bus_reg;

    // ********************************************************
    // decode and tick
    // ********************************************************
    logic wr_acc;
    logic rd_acc;
    logic running;
    logic dir_down;
    logic split;
    logic [2:0] psc_sel;
    logic psc_tick;
    logic timer_tick;
    logic wr_count;
    logic wr_period;
    logic wr_period_buffer;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic update;
    logic [15:0] count_next;
    logic [PSC_W-1:0] psc_mask;

    // a write is served in the ack state and read data is loaded in idle, so each access costs three cycles
    assign wr_acc = avs_write && bus_reg == BTC_BUS_ACK;
    assign rd_acc = avs_read && bus_reg == BTC_BUS_ACK;
    assign running = control_a_reg[`BTC_CTRL_ENABLE];
    assign split = control_a_reg[`BTC_CTRL_SPLIT];
    assign psc_sel = control_a_reg[`BTC_CTRL_PSC_HI:`BTC_CTRL_PSC_LO];
    // events may steer direction instead of the register bit
    assign dir_down = event_control_reg[`BTC_EV_DIR] ? event_dir
                                                     : control_a_reg[`BTC_CTRL_DIR]; // R10 R19
    // prescaler divides by 2^psc_sel
    assign psc_mask = PSC_W'((32'h1 << psc_sel) - 32'h1);
    assign psc_tick = (psc_reg & psc_mask) == '0;
    assign timer_tick = running && (event_control_reg[`BTC_EV_COUNT] ? event_tick
                                                                   : psc_tick); // R5 R8 R9
    assign wr_count = wr_acc && avs_address == `BTC_ADDR_COUNT;
    assign wr_period = wr_acc && avs_address == `BTC_ADDR_PERIOD;
    assign wr_period_buffer = wr_acc && avs_address == `BTC_ADDR_PERIOD_BUFFER;

    // split mode compares only the low byte
    always_comb begin
        if (split) begin
            at_bottom = count_value_reg[7:0] == 8'h00; // R2 R3 R20
            at_top = count_value_reg[7:0] == period_reg[7:0];
            at_max = count_value_reg[7:0] == 8'hff;
        end else begin
            at_bottom = count_value_reg == 16'h0000; // R2 R3
            at_top = count_value_reg == period_reg;
            at_max = count_value_reg == 16'hffff;
        end
    end

    assign update = timer_tick && (dir_down ? at_bottom : at_top) && !lock_update_reg; // R6 R22

    // only equality wraps, so a lowered period runs the count on to wrap
    always_comb begin
        count_next = count_value_reg;
        if (dir_down) begin
            if (at_bottom) begin
                count_next = split ? {count_value_reg[15:8] - 8'h01, period_reg[7:0]}
                                   : period_reg; // R12 R18
            end else begin
                count_next = split ? {count_value_reg[15:8], count_value_reg[7:0] - 8'h01}
                                   : count_value_reg - 16'h0001;
            end
        end else begin
            if (at_top) begin
                count_next = split ? {count_value_reg[15:8] + 8'h01, 8'h00}
                                   : 16'h0000; // R11 R16 R18
            end else begin
                count_next = count_value_reg + 16'h0001;
            end
        end
    end

    // ********************************************************
    // bus handshake
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_reg <= BTC_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            case (bus_reg)
                BTC_BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_reg <= BTC_BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                BTC_BUS_ACK: begin
                    bus_reg <= BTC_BUS_HOLD;
                    avs_waitrequest <= 1'b1;
                end
                BTC_BUS_HOLD: begin
                    bus_reg <= BTC_BUS_IDLE;
                end
                default: begin
                    bus_reg <= BTC_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // read data is loaded when waitrequest drops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= `BTC_RST_WORD;
        end else if (clk_en && bus_reg == BTC_BUS_IDLE && avs_read) begin
            avs_readdata <= `BTC_RST_WORD;
            case (avs_address)
                `BTC_ADDR_CTRL: avs_readdata <= control_a_reg;
                `BTC_ADDR_EVENT_CONTROL: avs_readdata <= event_control_reg;
                `BTC_ADDR_LOCK: avs_readdata <= {31'h0, lock_update_reg};
                `BTC_ADDR_STATUS: begin
                    avs_readdata[`BTC_ST_PERIOD_BUFFER_VALID] <= period_buffer_valid_reg;
                    avs_readdata[`BTC_ST_CMPBV0 +: NUM_CMP] <= compare_buffer_valid_n_reg;
                    avs_readdata[`BTC_ST_TOP] <= top_seen_reg;
                    avs_readdata[`BTC_ST_BOTTOM] <= bottom_seen_reg;
                    avs_readdata[`BTC_ST_MAX] <= max_seen_reg;
                    avs_readdata[`BTC_ST_MATCH0 +: NUM_CMP] <= match_seen_reg;
                end
                `BTC_ADDR_COUNT: avs_readdata <= {16'h0, count_value_reg};
                `BTC_ADDR_PERIOD: avs_readdata <= {16'h0, period_reg};
                `BTC_ADDR_PERIOD_BUFFER: avs_readdata <= {16'h0, period_buffer_reg};
                default: begin
                    for (int i = 0; i < NUM_CMP; i++) begin
                        if (avs_address == `BTC_ADDR_CMP0 + 4'(i)) begin
                            avs_readdata <= {16'h0, compare_value_n_reg[i]};
                        end
                        if (avs_address == `BTC_ADDR_CMPBUF0 + 4'(i)) begin
                            avs_readdata <= {16'h0, compare_buffer_n_reg[i]};
                        end
                    end
                end
            endcase
        end
    end

    // ********************************************************
    // control registers
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            control_a_reg <= `BTC_RST_WORD;
            event_control_reg <= `BTC_RST_WORD;
            lock_update_reg <= 1'b0;
        end else if (clk_en && wr_acc) begin
            if (avs_address == `BTC_ADDR_CTRL) begin
                control_a_reg <= avs_writedata; // R10
            end
            if (avs_address == `BTC_ADDR_EVENT_CONTROL) begin
                event_control_reg <= avs_writedata;
            end
            if (avs_address == `BTC_ADDR_LOCK) begin
                lock_update_reg <= avs_writedata[0];
            end
        end
    end

    // ********************************************************
    // prescaler and counter
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            psc_reg <= '0;
        end else if (clk_en) begin
            psc_reg <= running ? psc_reg + PSC_W'(1) : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_value_reg <= 16'h0000;
        end else if (clk_en) begin
            if (wr_count) begin
                count_value_reg <= avs_writedata[15:0]; // R13
            end else if (running && event_control_reg[`BTC_EV_RESTART] && event_restart) begin
                count_value_reg <= 16'h0000; // R19
            end else if (timer_tick) begin
                count_value_reg <= count_next; // R18
            end
        end
    end

    // ********************************************************
    // period and compare buffering
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            period_reg <= `BTC_RST_PERIOD;
            period_buffer_reg <= `BTC_RST_PERIOD;
            period_buffer_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_period_buffer) begin
                period_buffer_reg <= avs_writedata[15:0]; // R1
            end
            if (wr_period) begin
                period_reg <= avs_writedata[15:0]; // R15
            end else if (update && period_buffer_valid_reg) begin
                period_reg <= period_buffer_reg; // R6 R17
            end
            // a buffer write in the update cycle keeps the flag set
            if (wr_period_buffer) begin
                period_buffer_valid_reg <= 1'b1; // R7
            end else if (update) begin
                period_buffer_valid_reg <= 1'b0; // R7
            end
        end
    end

    for (genvar g = 0; g < NUM_CMP; g++) begin : gen_cmp
        logic wr_cmp;
        logic wr_cbuf;
        assign wr_cmp = wr_acc && avs_address == `BTC_ADDR_CMP0 + 4'(g);
        assign wr_cbuf = wr_acc && avs_address == `BTC_ADDR_CMPBUF0 + 4'(g);
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                compare_value_n_reg[g] <= 16'h0000;
                compare_buffer_n_reg[g] <= 16'h0000;
                compare_buffer_valid_n_reg[g] <= 1'b0;
            end else if (clk_en) begin
                if (wr_cbuf) begin
                    compare_buffer_n_reg[g] <= avs_writedata[15:0];
                end
                if (wr_cmp) begin
                    compare_value_n_reg[g] <= avs_writedata[15:0]; // R14
                end else if (update && compare_buffer_valid_n_reg[g]) begin
                    compare_value_n_reg[g] <= compare_buffer_n_reg[g]; // R6
                end
                if (wr_cbuf) begin
                    compare_buffer_valid_n_reg[g] <= 1'b1; // R7
                end else if (update) begin
                    compare_buffer_valid_n_reg[g] <= 1'b0; // R7
                end
            end
        end

        // match is registered on a tick, so outputs move one clock after the tick that sees it
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                waveform_out_n[g] <= 1'b0;
                match_seen_reg[g] <= 1'b0;
            end else if (clk_en) begin
                if (timer_tick) begin
                    waveform_out_n[g] <= split
                        ? count_value_reg[7:0] == compare_value_n_reg[g][7:0]
                        : count_value_reg == compare_value_n_reg[g]; // R4 R21
                end
                if (timer_tick && count_value_reg == compare_value_n_reg[g]) begin
                    match_seen_reg[g] <= 1'b1; // R3
                end else if (wr_acc && avs_address == `BTC_ADDR_STATUS
                             && avs_writedata[`BTC_ST_MATCH0 + g]) begin
                    match_seen_reg[g] <= 1'b0;
                end
            end
        end
    end

    // ********************************************************
    // top and bottom events
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            top_event <= 1'b0;
            bottom_event <= 1'b0;
            top_seen_reg <= 1'b0;
            bottom_seen_reg <= 1'b0;
            max_seen_reg <= 1'b0;
        end else if (clk_en) begin
            top_event <= timer_tick && at_top; // R4
            bottom_event <= timer_tick && at_bottom; // R4
            // hardware set wins over software clear
            if (timer_tick && at_top) begin
                top_seen_reg <= 1'b1;
            end else if (wr_acc && avs_address == `BTC_ADDR_STATUS
                         && avs_writedata[`BTC_ST_TOP]) begin
                top_seen_reg <= 1'b0;
            end
            if (timer_tick && at_bottom) begin
                bottom_seen_reg <= 1'b1;
            end else if (wr_acc && avs_address == `BTC_ADDR_STATUS
                         && avs_writedata[`BTC_ST_BOTTOM]) begin
                bottom_seen_reg <= 1'b0;
            end
            if (timer_tick && at_max) begin
                max_seen_reg <= 1'b1; // R2
            end else if (wr_acc && avs_address == `BTC_ADDR_STATUS
                         && avs_writedata[`BTC_ST_MAX]) begin
                max_seen_reg <= 1'b0;
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    chk_count_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && wr_count |=> count_value_reg == $past(avs_writedata[15:0])) // R13
        else $error("count write not immediate");
    chk_up_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && timer_tick && !wr_count && !dir_down && at_top && !split
        && !(event_control_reg[`BTC_EV_RESTART] && event_restart)
        |=> count_value_reg == 16'h0000) // R11
        else $error("up count did not wrap");
    chk_down_reload: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && timer_tick && !wr_count && dir_down && at_bottom && !split
        && !(event_control_reg[`BTC_EV_RESTART] && event_restart)
        |=> count_value_reg == $past(period_reg)) // R12
        else $error("down count did not reload");
    chk_period_buffer_valid: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && wr_period_buffer |=> period_buffer_valid_reg) // R7
        else $error("period buffer valid not set");
    chk_update_copy: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && update && period_buffer_valid_reg && !wr_period && !wr_period_buffer
        |=> period_reg == $past(period_buffer_reg) && !period_buffer_valid_reg) // R6
        else $error("period buffer not transferred");
    chk_lock_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && lock_update_reg && !wr_period |=> $stable(period_reg)) // R6
        else $error("period changed while locked");
    chk_top_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && timer_tick && at_top |=> top_event) // R4
        else $error("top event missing");
    chk_idle_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !running && !wr_count |=> $stable(count_value_reg)) // R8
        else $error("count moved while disabled");
    chk_bus_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && bus_reg == BTC_BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest)
        else $error("bus answer late");

endmodule

// *** btc_regs.svh ***
`ifndef BTC_REGS_SVH
`define BTC_REGS_SVH
// register word addresses (byte address = 4 * index)
`define BTC_ADDR_CTRL      4'h0
`define BTC_ADDR_EVENT_CONTROL    4'h1
`define BTC_ADDR_LOCK      4'h2
`define BTC_ADDR_STATUS    4'h3
`define BTC_ADDR_COUNT     4'h4
`define BTC_ADDR_PERIOD    4'h5
`define BTC_ADDR_PERIOD_BUFFER    4'h6
`define BTC_ADDR_CMP0      4'h8
`define BTC_ADDR_CMPBUF0   4'hc
// control register fields
`define BTC_CTRL_ENABLE    0
`define BTC_CTRL_DIR       1
`define BTC_CTRL_SPLIT     2
`define BTC_CTRL_PSC_LO    4
`define BTC_CTRL_PSC_HI    6
// event control fields
`define BTC_EV_COUNT       0
`define BTC_EV_DIR         1
`define BTC_EV_RESTART     2
// status fields
`define BTC_ST_PERIOD_BUFFER_VALID       0
`define BTC_ST_CMPBV0      1
`define BTC_ST_TOP         4
`define BTC_ST_BOTTOM      5
`define BTC_ST_MAX         6
`define BTC_ST_MATCH0      8
// reset values
`define BTC_RST_PERIOD     16'hffff
`define BTC_RST_WORD       32'h0000_0000
`endif

// *** btc_pkg.sv ***
package btc_pkg;
    typedef enum logic [2:0] {
        BTC_BUS_IDLE = 3'b001,
        BTC_BUS_ACK = 3'b010,
        BTC_BUS_HOLD = 3'b100
    } btc_bus_state_t;
endpackage

// *** btc_evsys_model.sv ***
`timescale 1ns/100ps
module btc_evsys_model (
    // clock
    input wire logic clk_sys,
    // event lines towards the timer
    output logic event_tick,
    output logic event_dir,
    output logic event_restart
);
    initial begin
        event_tick = 1'b0;
        event_dir = 1'b0;
        event_restart = 1'b0;
    end
    // ***************
    // event sources
    // ***************
    // a gap of zero keeps the line high, so back-to-back ticks are exercised too
    task automatic send_ticks(input int n);
        int gap;
        for (int i = 0; i < n; i++) begin
            gap = $urandom_range(2);
            event_tick <= 1'b1;
            @(posedge clk_sys);
            if (gap > 0 || i == n - 1) begin
                event_tick <= 1'b0;
                repeat (gap) @(posedge clk_sys);
            end
        end
        @(posedge clk_sys);
    endtask
    task automatic set_dir(input logic v);
        event_dir <= v;
        @(posedge clk_sys);
    endtask
    task automatic restart();
        event_restart <= 1'b1;
        @(posedge clk_sys);
        event_restart <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/100ps
`include "btc_regs.svh"
module testbench;
    logic clk_sys, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic event_tick, event_dir, event_restart, top_event, bottom_event;
    logic [2:0] waveform_out_n, wav_q, m_cbv, m_ev;
    logic [15:0] m_cnt, m_per, m_pbuf, p;
    logic [15:0] m_cmp[3], m_cbuf[3];
    logic m_pbv, m_lock, m_dir, m_evdir;
    int n_errors, comparisons, cycles, s_top, s_bot, e_top, e_bot;
    int s_wav[3], e_wav[3];
    btc_timer #(.NUM_CMP(3), .PSC_W(10)) u_btc_timer (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_tick(event_tick), .event_dir(event_dir),
        .event_restart(event_restart), .top_event(top_event), .bottom_event(bottom_event),
        .waveform_out_n(waveform_out_n));
    btc_evsys_model u_btc_evsys_model (.clk_sys(clk_sys), .event_tick(event_tick),
        .event_dir(event_dir), .event_restart(event_restart));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // outputs are registered, so sampling them at the edge is race free
    always @(posedge clk_sys) begin
        cycles++;
        if (reset_n === 1'b1) begin
            s_top += (top_event === 1'b1);
            s_bot += (bottom_event === 1'b1);
            for (int i = 0; i < 3; i++) s_wav[i] += (waveform_out_n[i] === 1'b1 && !wav_q[i]);
        end
        wav_q <= waveform_out_n;
        if (cycles == 10000) begin
            n_errors++;
            test_done();
        end
    end
    // ***************
    // tasks and expectations
    // ***************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read data is taken in the cycle whose closing edge sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
        case (a)
            `BTC_ADDR_CTRL: m_dir = d[1];
            `BTC_ADDR_EVENT_CONTROL: m_ev = d[2:0];
            `BTC_ADDR_LOCK: m_lock = d[0];
            `BTC_ADDR_COUNT: m_cnt = d[15:0];
            `BTC_ADDR_PERIOD: m_per = d[15:0];
            `BTC_ADDR_PERIOD_BUFFER: {m_pbv, m_pbuf} = {1'b1, d[15:0]};
            4'h8, 4'h9, 4'ha: m_cmp[a - 4'h8] = d[15:0];
            4'hc, 4'hd, 4'he: {m_cbv[a - 4'hc], m_cbuf[a - 4'hc]} = {1'b1, d[15:0]};
            default: ;
        endcase
    endtask
    // down reload uses the period in force before any update on the same tick
    function automatic void mtick();
        logic dn, upd;
        dn = m_ev[1] ? m_evdir : m_dir;
        e_top += (m_cnt == m_per);
        e_bot += (m_cnt == 16'h0000);
        for (int i = 0; i < 3; i++) e_wav[i] += (m_cnt == m_cmp[i]);
        upd = dn ? (m_cnt == 16'h0000) : (m_cnt == m_per);
        if (dn) m_cnt = (m_cnt == 16'h0000) ? m_per : m_cnt - 16'h0001;
        else m_cnt = (m_cnt == m_per) ? 16'h0000 : m_cnt + 16'h0001;
        if (upd && !m_lock) begin
            if (m_pbv) m_per = m_pbuf;
            for (int i = 0; i < 3; i++) if (m_cbv[i]) m_cmp[i] = m_cbuf[i];
            {m_pbv, m_cbv} = 4'h0;
        end
    endfunction
    task automatic tick(input int n);
        u_btc_evsys_model.send_ticks(n);
        repeat (n) mtick();
    endtask
    task automatic chk_state(string name);
        repeat (4) @(posedge clk_sys);
        bus(1'b0, `BTC_ADDR_COUNT, 32'h0, rd);
        check(rd, {16'h0000, m_cnt});
        bus(1'b0, `BTC_ADDR_PERIOD, 32'h0, rd);
        check(rd, {16'h0000, m_per});
        bus(1'b0, `BTC_ADDR_STATUS, 32'h0, rd);
        check({28'h0, rd[3:0]}, {28'h0, m_cbv, m_pbv});
        check(s_top, e_top);
        check(s_bot, e_bot);
        for (int i = 0; i < 3; i++) check(s_wav[i], e_wav[i]);
        $display("test %s done", name);
    endtask
    // ***************
    // main sequence
    // ***************
    initial begin
        {avs_read, avs_write, clk_en, reset_n} = 4'b0010;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        {m_dir, m_evdir, m_lock, m_pbv, m_cbv, m_ev} = 10'h0;
        {m_cnt, m_per, m_pbuf} = {16'h0, 16'hffff, 16'h0};
        foreach (m_cmp[i]) {m_cmp[i], m_cbuf[i]} = 32'h0;
        wav_q = 3'h0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        void'($urandom(7433));
        for (int a = 0; a < 16; a++) begin
            bus(1'b0, a[3:0], 32'h0, rd);
            check(rd, (a == `BTC_ADDR_PERIOD || a == `BTC_ADDR_PERIOD_BUFFER)
                      ? `BTC_RST_PERIOD : 32'h0);
        end
        wr(4'h7, $urandom());
        bus(1'b0, 4'h7, 32'h0, rd);
        check(rd, 32'h0);
        for (int a = 4; a < 11; a++) begin
            if (a != 6 && a != 7) begin
                wr(a[3:0], $urandom());
                bus(1'b0, a[3:0], 32'h0, rd);
                check(rd, {16'h0, (a == 4) ? m_cnt : (a == 5) ? m_per : m_cmp[a - 8]});
            end
        end
        $display("test registers done");
        p = 16'h4 + 16'($urandom_range(8));
        wr(`BTC_ADDR_PERIOD, p);
        for (int i = 0; i < 3; i++) wr(4'h8 + i[3:0], $urandom_range(p));
        wr(`BTC_ADDR_COUNT, 32'h0);
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h1);
        wr(`BTC_ADDR_CTRL, 32'h1);
        tick(20 + $urandom_range(10));
        chk_state("count_up");
        wr(`BTC_ADDR_PERIOD_BUFFER, 32'h3 + $urandom_range(6));
        wr(4'hd, $urandom_range(3));
        wr(`BTC_ADDR_LOCK, 32'h1);
        tick(2 * (p + 1));
        chk_state("locked");
        wr(`BTC_ADDR_LOCK, 32'h0);
        tick(2 * (p + 1));
        chk_state("buffered");
        wr(4'he, $urandom_range(3));
        wr(`BTC_ADDR_CTRL, 32'h3);
        tick(15 + $urandom_range(10));
        chk_state("count_down");
        wr(`BTC_ADDR_CTRL, 32'h1);
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h3);
        for (int d = 0; d < 2; d++) begin
            u_btc_evsys_model.set_dir(d == 0);
            m_evdir = (d == 0);
            tick(12);
            chk_state("event_dir");
        end
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h1);
        wr(`BTC_ADDR_COUNT, 32'hfffd);
        tick(6 + $urandom_range(6));
        chk_state("wrap");
        wr(`BTC_ADDR_PERIOD, 32'h5);
        chk_state("period_write");
        // ticks offered while the clock enable is low must leave no trace
        clk_en <= 1'b0;
        u_btc_evsys_model.send_ticks(5);
        clk_en <= 1'b1;
        chk_state("clock_enable");
        wr(`BTC_ADDR_COUNT, 32'h3);
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h5);
        u_btc_evsys_model.restart();
        bus(1'b0, `BTC_ADDR_COUNT, 32'h0, rd);
        check(rd, 32'h0);
        $display("test restart done");
        // split down count: low byte reloads from period low byte, high byte steps
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h1);
        wr(`BTC_ADDR_PERIOD, 32'h3);
        wr(`BTC_ADDR_COUNT, 32'h0201);
        wr(`BTC_ADDR_CTRL, 32'h7);
        u_btc_evsys_model.send_ticks(3);
        bus(1'b0, `BTC_ADDR_COUNT, 32'h0, rd);
        check(rd, 32'h0102);
        $display("test split done");
        wr(`BTC_ADDR_CTRL, 32'h0);
        wr(`BTC_ADDR_EVENT_CONTROL, 32'h0);
        wr(`BTC_ADDR_PERIOD, 32'hffff);
        wr(`BTC_ADDR_COUNT, 32'h0);
        wr(`BTC_ADDR_CTRL, 32'h21);
        repeat (40) @(posedge clk_sys);
        bus(1'b0, `BTC_ADDR_COUNT, 32'h0, rd);
        check({31'h0, (rd >= 32'd8 && rd <= 32'd12)}, 32'h1);
        $display("test prescaler done");
        test_done();
    end
endmodule
